// >>> ppi_host_pkg.sv
`default_nettype none
package ppi_host_pkg;

    // Clock and pin timing of the device bus.
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PULSE_NS    = 300;
    localparam int T_HOLD_NS     = 30;
    localparam int T_RECOVER_NS  = 850;
    // Least times round up to whole cycles.
    localparam int PULSE_CYC   = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC    = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC =
        (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W   = 8;
    localparam int CNT_MAX = 255;

    // Device register map, selected by the two address lines.
    localparam logic [1:0] PORT_A_DATA   = 2'h0;
    localparam logic [1:0] PORT_B_DATA   = 2'h1;
    localparam logic [1:0] PORT_C_DATA   = 2'h2;
    localparam logic [1:0] CONTROL_WORDS = 2'h3;

    // Control word fields.
    localparam int          CW_KIND_BIT   = 7;
    localparam logic [2:0]  BIDIR_PAD     = 3'h0;
    localparam logic [1:0]  BIDIR_HEAD    = 2'h3;
    localparam logic [2:0]  BITCMD_PAD    = 3'h0;
    localparam logic [2:0]  PC_GRP_A_IRQ_ENABLE = 3'h4;
    localparam logic [2:0]  PC_GRP_B_IRQ_ENABLE = 3'h2;

    // Wishbone register byte offsets of the controller.
    localparam logic [4:0] REG_CMD    = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_BITCMD = 5'h08;
    localparam logic [4:0] REG_DEVRST = 5'h0c;
    localparam logic [4:0] REG_BIDIR  = 5'h10;
    localparam logic [4:0] REG_IRQ_ENABLE   = 5'h14;

    // CMD register field positions.
    localparam int CMD_CODE_LSB = 8;
    localparam int CMD_READ_BIT = 10;
    // BITCMD register field positions.
    localparam int BIT_VALUE_POS = 3;
    // IRQ_ENABLE register field positions.
    localparam int IRQ_ENABLE_GROUP_POS = 1;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_PULSE,
        PH_HOLD,
        PH_RECOVER
    } phase_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       addr_sel_hi;
        logic       addr_sel_lo;
        logic [7:0] data_out;
        logic       data_oe_n;
        logic       dev_reset;
    } pin_out_t;

    typedef struct packed {
        logic [7:0] data_in;
        logic       irq_request_a;
        logic       irq_request_b;
    } pin_in_t;

    typedef struct packed {
        phase_t           phase;
        logic [CNT_W-1:0] cnt;
        logic             is_read;
        logic [7:0]       rdata;
        logic             refused;
        logic             done;
        logic             ack;
        logic [31:0]      wb_dat;
        pin_out_t         pins;
    } host_state_t;

    localparam pin_out_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        addr_sel_hi: 1'b0, addr_sel_lo: 1'b0, data_out: 8'h00,
        data_oe_n: 1'b1, dev_reset: 1'b1};

    localparam host_state_t STATE_RESET = '{phase: PH_IDLE, cnt: 8'h00,
        is_read: 1'b0, rdata: 8'h00, refused: 1'b0, done: 1'b0,
        ack: 1'b0, wb_dat: 32'h0000_0000, pins: PINS_IDLE};

endpackage
`default_nettype wire

// >>> ppi_sync2.sv
`default_nettype none
module ppi_sync2 #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> ppi_host.sv
// Operation
// - Chip select low; address 00 A, 01 B, 10 C, 11 control write.
// - Bus floats when unselected or idle; never read address code 11.
// - Group A enable via port C bit 4, group B via bit 2.
// - Peripheral pulses acknowledge low after taking the output data.
// - Bidirectional word: bits 7,6 set, bit 2 group B mode, 1,0 dirs.
//
// Added by the designer: the Wishbone register port.
`default_nettype none
module ppi_host
    import ppi_host_pkg::*;
#(
    parameter int PULSE_LEN   = PULSE_CYC,
    parameter int HOLD_LEN    = HOLD_CYC,
    parameter int RECOVER_LEN = RECOVER_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire pin_in_t     dev_in,
    output var  pin_out_t    dev_out
);

    if (PULSE_LEN < 1 || PULSE_LEN > CNT_MAX || HOLD_LEN < 1 ||
        RECOVER_LEN <= HOLD_LEN || RECOVER_LEN > CNT_MAX) begin : g_check
        $error("ppi_host: pin timing counts out of range");
    end

    host_state_t state;
    host_state_t next_state;
    pin_in_t     dev_sync;
    logic        wb_req;
    logic        wr_ok;

    // Every pin input is synchronised before any logic looks at it.
    ppi_sync2 #(
        .WIDTH ($bits(pin_in_t))
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (dev_in),
        .sync_out (dev_sync)
    );

    function automatic host_state_t start_cycle(input host_state_t s,
                                                input logic        rd,
                                                input logic [1:0]  code,
                                                input logic [7:0]  data);
        host_state_t r;
        r                  = s;
        r.phase            = PH_SETUP;
        r.cnt              = '0;
        r.is_read          = rd;
        r.refused          = 1'b0;
        r.done             = 1'b0;
        r.pins.cs_n        = 1'b0;
        r.pins.addr_sel_hi = code[1];
        r.pins.addr_sel_lo = code[0];
        r.pins.data_out    = data;
        // The device drives the bus during a read, so we let go of it.
        r.pins.data_oe_n   = rd;
        return r;
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !state.ack;
    assign wr_ok  = wb_req && wb_we_i && (wb_sel_i[1:0] == 2'h3);

    always_comb begin
        next_state     = state;
        next_state.ack = 1'b0;
        if (wb_req) begin
            next_state.ack    = 1'b1;
            next_state.wb_dat = 32'h0000_0000;
            if (wb_adr_i == REG_STATUS) begin
                next_state.wb_dat[0]    = state.phase != PH_IDLE;
                next_state.wb_dat[1]    = state.refused;
                next_state.wb_dat[2]    = state.done;
                next_state.wb_dat[3]    = dev_sync.irq_request_a;
                next_state.wb_dat[4]    = dev_sync.irq_request_b;
                next_state.wb_dat[15:8] = state.rdata;
            end else if (wb_adr_i == REG_DEVRST) begin
                next_state.wb_dat[0] = state.pins.dev_reset;
            end
        end
        // Commands build on next_state so the ack and reply set above stay.
        if (wr_ok) begin
            if (wb_adr_i == REG_DEVRST) begin
                next_state.pins.dev_reset = wb_dat_i[0];
            end else if (wb_adr_i == REG_CMD || wb_adr_i == REG_BITCMD ||
                         wb_adr_i == REG_BIDIR || wb_adr_i == REG_IRQ_ENABLE) begin
                if (state.phase != PH_IDLE) begin
                    next_state.refused = 1'b1;
                end else if (wb_adr_i == REG_CMD) begin
                    // A read of the control address is never put on the pins.
                    if (wb_dat_i[CMD_READ_BIT] &&
                        wb_dat_i[CMD_CODE_LSB+:2] == CONTROL_WORDS) begin
                        next_state.refused = 1'b1;
                    end else begin
                        next_state = start_cycle(next_state,
                            wb_dat_i[CMD_READ_BIT],
                            wb_dat_i[CMD_CODE_LSB+:2], wb_dat_i[7:0]);
                    end
                end else if (wb_adr_i == REG_BITCMD) begin
                    next_state = start_cycle(next_state, 1'b0, CONTROL_WORDS,
                        {1'b0, BITCMD_PAD, wb_dat_i[2:0],
                         wb_dat_i[BIT_VALUE_POS]});
                end else if (wb_adr_i == REG_BIDIR) begin
                    next_state = start_cycle(next_state, 1'b0, CONTROL_WORDS,
                        {BIDIR_HEAD, BIDIR_PAD, wb_dat_i[2:0]});
                end else begin
                    next_state = start_cycle(next_state, 1'b0, CONTROL_WORDS,
                        {1'b0, BITCMD_PAD,
                         wb_dat_i[IRQ_ENABLE_GROUP_POS] ? PC_GRP_B_IRQ_ENABLE
                                                  : PC_GRP_A_IRQ_ENABLE,
                         wb_dat_i[0]});
                end
            end
        end
        case (state.phase)
            PH_SETUP: begin
                next_state.phase = PH_PULSE;
                next_state.cnt   = '0;
                if (state.is_read) begin
                    next_state.pins.rd_n = 1'b0;
                end else begin
                    next_state.pins.wr_n = 1'b0;
                end
            end
            PH_PULSE: begin
                if (state.cnt == CNT_W'(PULSE_LEN - 1)) begin
                    next_state.phase     = PH_HOLD;
                    next_state.cnt       = '0;
                    next_state.pins.rd_n = 1'b1;
                    next_state.pins.wr_n = 1'b1;
                    // Sampled late in the pulse, after the access time.
                    if (state.is_read) begin
                        next_state.rdata = dev_sync.data_in;
                    end
                end else begin
                    next_state.cnt = state.cnt + 1'b1;
                end
            end
            PH_HOLD: begin
                if (state.cnt == CNT_W'(HOLD_LEN - 1)) begin
                    next_state.phase          = PH_RECOVER;
                    next_state.cnt            = '0;
                    next_state.pins.cs_n      = 1'b1;
                    next_state.pins.data_oe_n = 1'b1;
                end else begin
                    next_state.cnt = state.cnt + 1'b1;
                end
            end
            PH_RECOVER: begin
                // Recovery is counted from the strobe rise, hold included.
                if (state.cnt == CNT_W'(RECOVER_LEN - HOLD_LEN - 1)) begin
                    next_state.phase = PH_IDLE;
                    next_state.done  = 1'b1;
                end else begin
                    next_state.cnt = state.cnt + 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign wb_dat_o = state.wb_dat;
    assign wb_ack_o = state.ack;
    assign dev_out  = state.pins;

    // Helper counters seen only by the assertions.
    logic             strobe_low;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    assign strobe_low = !state.pins.rd_n || !state.pins.wr_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt  <= '0;
            high_cnt <= '1;
        end else begin
            low_cnt  <= !strobe_low ? '0 :
                        (low_cnt == '1) ? low_cnt : low_cnt + 1'b1;
            high_cnt <= strobe_low ? '0 :
                        (high_cnt == '1) ? high_cnt : high_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_NO_DOUBLE_STROBE: assert property (
        !(!state.pins.rd_n && !state.pins.wr_n))
        else $error("read and write strobes low together");
    AST_NO_CTRL_READ: assert property (
        !state.pins.rd_n |->
            {state.pins.addr_sel_hi, state.pins.addr_sel_lo} != CONTROL_WORDS)
        else $error("read issued at control address");
    AST_STROBE_SELECTED: assert property (
        strobe_low |-> !state.pins.cs_n)
        else $error("strobe without chip select");
    AST_READ_BUS_FREE: assert property (
        !state.pins.rd_n |-> state.pins.data_oe_n)
        else $error("host drives data bus during a read");
    AST_WRITE_DATA_STABLE: assert property (
        !state.pins.wr_n |-> !state.pins.data_oe_n &&
            $stable(state.pins.data_out))
        else $error("write data not held during write strobe");
    AST_PULSE_WIDTH: assert property (
        $fell(strobe_low) |-> low_cnt == CNT_W'(PULSE_LEN))
        else $error("strobe pulse width wrong");
    AST_RECOVERY: assert property (
        $rose(strobe_low) |-> $past(high_cnt) >= CNT_W'(RECOVER_LEN))
        else $error("strobe recovery too short");
    AST_BITCMD_WORD: assert property (
        wr_ok && wb_adr_i == REG_BITCMD && state.phase == PH_IDLE |=>
            !state.pins.cs_n && state.pins.addr_sel_hi &&
            state.pins.addr_sel_lo &&
            state.pins.data_out == {1'b0, BITCMD_PAD, $past(wb_dat_i[2:0]),
                                    $past(wb_dat_i[BIT_VALUE_POS])})
        else $error("bit command word malformed");
    AST_BIDIR_WORD: assert property (
        wr_ok && wb_adr_i == REG_BIDIR && state.phase == PH_IDLE |=>
            state.pins.data_out[7:6] == BIDIR_HEAD &&
            state.pins.data_out[2:0] == $past(wb_dat_i[2:0]))
        else $error("bidirectional mode word malformed");
    AST_DEVRESET: assert property (
        wr_ok && wb_adr_i == REG_DEVRST |=>
            state.pins.dev_reset == $past(wb_dat_i[0]))
        else $error("device reset not updated");
    AST_WB_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack timing wrong");

    COV_READ_DONE: cover property ($rose(state.pins.rd_n) ##[1:200]
        state.done);
    COV_WRITE_DONE: cover property ($rose(state.pins.wr_n) ##[1:200]
        state.done);
    COV_REFUSED: cover property ($rose(state.refused));
    COV_BITCMD: cover property (wr_ok && wb_adr_i == REG_BITCMD);

endmodule
`default_nettype wire

// >>> parallel_io_unit.sv
`default_nettype none
module parallel_io_unit
    import ppi_host_pkg::*;
(
    input  wire logic [7:0] bus_in,
    input  wire pin_out_t   pins,
    input  wire logic [7:0] pa_in,
    input  wire logic [7:0] pb_in,
    input  wire logic       peripheral_strobe_n,
    input  wire logic       periph_ack_n,
    output var  logic [7:0] bus_val,
    output var  logic       irq_request,
    output var  logic       output_buffer_full_n,
    output var  logic [7:0] pa_out,
    output var  logic       pa_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_w, lat_a, lat_b, lat_c, in_lat, rd_val;
    logic [7:0] last_val = 8'h00;
    logic [3:0] dir_in;
    logic       input_buffer_full, grp_a_irq_enable, strobed, rd_on, sel_a;
    logic       out_side_irq_enable, out_mode, bidir;
    logic       p_wr = 1'b1;
    logic       p_ack = 1'b1;
    logic       p_rd = 1'b1;
    logic       p_stb = 1'b1;
    logic [1:0] code;

    assign code = {pins.addr_sel_hi, pins.addr_sel_lo};
    assign sel_a = !pins.cs_n && code == PORT_A_DATA;
    // Only group A handshakes are modelled; group B strobed modes act as 0.
    assign bidir    = mode_w[7:6] == 2'b11;
    assign out_mode = mode_w[7:4] == 4'ha;
    assign strobed  = mode_w[7:4] == 4'hb || bidir;
    assign pa_out   = lat_a;
    // In mode 2 port A floats unless the peripheral holds acknowledge low.
    assign pa_oe_n  = bidir ? periph_ack_n : dir_in[3];
    assign rd_on = !pins.cs_n && !pins.rd_n && code != CONTROL_WORDS;
    // A floating bus shows the inverse of its last value, so a host that
    // samples outside the read window cannot pass by luck.
    assign bus_val = rd_on ? rd_val : ~last_val;

    always_comb begin
        rd_val = lat_c;
        if (code == PORT_A_DATA) begin
            rd_val = strobed ? in_lat : (dir_in[3] ? pa_in : lat_a);
        end else if (code == PORT_B_DATA) begin
            rd_val = dir_in[1] ? pb_in : lat_b;
        end else if (bidir) begin
            rd_val = {output_buffer_full_n, out_side_irq_enable, input_buffer_full,
                      grp_a_irq_enable, irq_request, lat_c[2:0]};
        end else if (out_mode) begin
            rd_val = {output_buffer_full_n, out_side_irq_enable, 2'b00,
                      irq_request, lat_c[2:0]};
        end else if (strobed) begin
            rd_val = {2'b00, input_buffer_full, grp_a_irq_enable, irq_request,
                      lat_c[2:0]};
        end
    end

    always @(pins, pa_in, peripheral_strobe_n, periph_ack_n) begin
        if (pins.dev_reset) begin
            mode_w = 8'h00;
            dir_in = 4'hf;
            {lat_a, lat_b, lat_c} = '0;
            {input_buffer_full, grp_a_irq_enable, irq_request} = '0;
            out_side_irq_enable  = 1'b0;
            output_buffer_full_n = 1'b1;
        end else begin
            if (!pins.wr_n && p_wr && sel_a && (out_mode || bidir))
                irq_request = 1'b0;
            if (pins.wr_n && !p_wr && !pins.cs_n) begin
                if (code == PORT_A_DATA) begin
                    lat_a = bus_in;
                    if (out_mode || bidir)
                        output_buffer_full_n = 1'b0;
                end else if (code == PORT_B_DATA) lat_b = bus_in;
                else if (code == PORT_C_DATA) lat_c = bus_in;
                else if (bus_in[CW_KIND_BIT]) begin
                    mode_w = bus_in;
                    dir_in = {bus_in[4:3], bus_in[1:0]};
                    output_buffer_full_n = 1'b1;
                    irq_request = 1'b0;
                end else begin
                    lat_c[bus_in[3:1]] = bus_in[0];
                    if (bus_in[3:1] == PC_GRP_A_IRQ_ENABLE)
                        grp_a_irq_enable = bus_in[0];
                    if (bus_in[3:1] == 3'h6)
                        out_side_irq_enable = bus_in[0];
                end
            end
            if (!periph_ack_n && p_ack && (out_mode || bidir))
                output_buffer_full_n = 1'b1;
            if (periph_ack_n && !p_ack && output_buffer_full_n &&
                out_side_irq_enable && (out_mode || bidir))
                irq_request = 1'b1;
            if (strobed && !peripheral_strobe_n) begin
                in_lat = pa_in;
                input_buffer_full = 1'b1;
            end
            if (peripheral_strobe_n && !p_stb && input_buffer_full && grp_a_irq_enable)
                irq_request = 1'b1;
            if (!pins.rd_n && p_rd && sel_a) irq_request = 1'b0;
            if (pins.rd_n && !p_rd && sel_a) input_buffer_full = 1'b0;
        end
        if (pins.rd_n && !p_rd) last_val = rd_val;
        p_wr = pins.wr_n;
        p_rd = pins.rd_n;
        p_stb = peripheral_strobe_n;
        p_ack = periph_ack_n;
    end
endmodule
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb
    import ppi_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PL = 8;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic        ack, irq;
    logic [7:0]  bus, dev_val;
    logic [7:0]  pa_in = 8'h00;
    logic [7:0]  pb_in = 8'h00;
    logic        stb_n = 1'b1;
    logic        periph_ack_n = 1'b1;
    logic        out_full_n, pa_oe_n;
    logic [7:0]  pa_out;
    logic [7:0]  exp_c = 8'haa;
    pin_in_t     dev_in;
    pin_out_t    dev_out;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          low_cnt = 0;
    int          last_low = 0;

    always #2.5 clk = ~clk;
    assign bus = dev_out.data_oe_n ? dev_val : dev_out.data_out;
    assign dev_in = '{data_in: bus, irq_request_a: irq, irq_request_b: 1'b0};

    ppi_host #(.PULSE_LEN(PL), .HOLD_LEN(2), .RECOVER_LEN(12)) dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .dev_in(dev_in),
        .dev_out(dev_out));

    parallel_io_unit dev (.bus_in(bus), .pins(dev_out), .pa_in(pa_in),
        .pb_in(pb_in), .peripheral_strobe_n(stb_n), .bus_val(dev_val),
        .irq_request(irq), .periph_ack_n(periph_ack_n),
        .output_buffer_full_n(out_full_n), .pa_out(pa_out),
        .pa_oe_n(pa_oe_n));

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for ack with no assumed latency; a lost ack counts as a fault.
    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        if (n >= 40) check(32'h0, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (n >= 200) check(32'h0, 32'h1);
    endtask

    task automatic cmd(input logic r, input logic [1:0] c,
                       input logic [7:0] d);
        wb(1'b1, REG_CMD, {21'h0, r, c, d});
        idle();
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        low_cnt <= dev_out.wr_n ? 0 : low_cnt + 1;
        if (dev_out.wr_n && low_cnt != 0) last_low <= low_cnt;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(32'(dev_out), 32'(PINS_IDLE));
        wb(1'b0, REG_DEVRST, 32'h0);
        check(q, 32'h1);
        wb(1'b1, REG_DEVRST, 32'h0);
        wb(1'b0, 5'h18, 32'h0);
        check(q, 32'h0);
        cmd(1'b0, CONTROL_WORDS, 8'h82);
        check(last_low, PL);
        cmd(1'b0, PORT_A_DATA, 8'h5a);
        pb_in <= 8'hc6;
        cmd(1'b1, PORT_A_DATA, 8'h00);
        check(q[15:8], 8'h5a);
        cmd(1'b1, PORT_B_DATA, 8'h00);
        check(q[15:8], 8'hc6);
        cmd(1'b0, PORT_C_DATA, 8'haa);
        for (int i = 0; i < 8; i++) begin
            exp_c[i] = (i % 2 == 0);
            wb(1'b1, REG_BITCMD, {28'h0, exp_c[i], 3'(i)});
            idle();
            cmd(1'b1, PORT_C_DATA, 8'h00);
            check(q[15:8], exp_c);
        end
        // A read of the control address must be refused, never issued.
        wb(1'b1, REG_CMD, {21'h0, 1'b1, 2'h3, 8'h00});
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[1:0], 2'b10);
        wb(1'b1, REG_CMD, 32'h0000_0011);
        wb(1'b1, REG_CMD, 32'h0000_0022);
        idle();
        check(q[2:0], 3'b110);
        cmd(1'b1, PORT_A_DATA, 8'h00);
        check(q[15:8], 8'h11);
        cmd(1'b0, CONTROL_WORDS, 8'hb0);
        wb(1'b1, REG_IRQ_ENABLE, 32'h1);
        idle();
        pa_in <= 8'h3c;
        @(posedge clk);
        stb_n <= 1'b0;
        repeat (4) @(posedge clk);
        stb_n <= 1'b1;
        repeat (4) @(posedge clk);
        pa_in <= 8'h00;
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[4:3], 2'b01);
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check(q[13:11], 3'b111);
        cmd(1'b1, PORT_A_DATA, 8'h00);
        check(q[15:8], 8'h3c);
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[3], 1'b0);
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check(q[13:11], 3'b010);
        // Group A strobed output: the peripheral takes the byte, then acks.
        cmd(1'b0, CONTROL_WORDS, 8'ha0);
        wb(1'b1, REG_BITCMD, 32'h0000_000e);
        idle();
        cmd(1'b0, PORT_A_DATA, 8'h96);
        check({out_full_n, pa_oe_n, pa_out}, {2'b00, 8'h96});
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check({q[15:14], q[11]}, 3'b010);
        periph_ack_n <= 1'b0;
        repeat (4) @(posedge clk);
        periph_ack_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[4:3], 2'b01);
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check({q[15], q[11]}, 2'b11);
        cmd(1'b0, PORT_A_DATA, 8'h69);
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[4:3], 2'b00);
        // Bidirectional port A while group B keeps its own direction.
        wb(1'b1, REG_BIDIR, 32'h0000_0002);
        idle();
        pb_in <= 8'h3a;
        cmd(1'b1, PORT_B_DATA, 8'h00);
        check(q[15:8], 8'h3a);
        cmd(1'b0, PORT_A_DATA, 8'hd2);
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check({q[15:14], pa_oe_n}, 3'b011);
        periph_ack_n <= 1'b0;
        @(posedge clk);
        check({pa_oe_n, pa_out}, {1'b0, 8'hd2});
        periph_ack_n <= 1'b1;
        @(posedge clk);
        check(pa_oe_n, 1'b1);
        repeat (4) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        check(q[4:3], 2'b01);
        pa_in <= 8'h47;
        stb_n <= 1'b0;
        repeat (4) @(posedge clk);
        stb_n <= 1'b1;
        cmd(1'b1, PORT_C_DATA, 8'h00);
        check({q[15], q[13]}, 2'b11);
        cmd(1'b1, PORT_A_DATA, 8'h00);
        check(q[15:8], 8'h47);
        print_verdict();
    end
endmodule
`default_nettype wire
